// ==== hdl/rvd_consts.vh ====
// constants for the reset and vector dispatch block
`ifndef RVD_CONSTS_VH
`define RVD_CONSTS_VH
`define RVD_OSC_WAIT_CYC 7'h40
`define RVD_HOLD_CYC 7'h20
`define RVD_ADR_CTRL 4'h0
`define RVD_ADR_VBASE 4'h4
`define RVD_ADR_STAT 4'h8
`define RVD_ADR_VECREQ 4'hc
`define RVD_CTRL_KEY_EN 0
`define RVD_CTRL_WDT_EN 1
`define RVD_CTRL_WDT_SEL 2
`define RVD_CTRL_KEY_MASK_LSB 4
`define RVD_CTRL_RST 8'h00
`define RVD_VBASE_RST 16'h0080
`define RVD_VEC_RESET 5'h00
`define RVD_VEC_NMI 5'h02
`define RVD_MASKABLE_MAP 32'h0005_4d90
`define RVD_MAX_VEC 5'h1f
`define RVD_ST_HOLD 2'h0
`define RVD_ST_OSC 2'h1
`define RVD_ST_IRH 2'h2
`define RVD_ST_RUN 2'h3
`endif

// ==== hdl/rvd_reset_dispatch.v ====
// reset source combiner, release sequencer and vector address dispatch
// Summary of operation
// - three reset sources: pin, port key entry, watchdog; any resets cpu and peripherals
// - pin low holds reset; pin high starts the reset sequence
// - key reset fires when all software-selected key inputs are low together
// - key reset stays inactive until software enables it
// - watchdog overflow resets when select bit is 1, else raises nmi
// - watchdog reset path is off until software enables it
// - after release wait 64 then 32 oscillator cycles before cpu starts
// - cpu runs on the internal oscillator clock after release
// - cpu fetches reset vector from table start and runs from there
// - reset clears eight general registers and stack pointer to zero
// - reset clears processor status word: level 0, interrupts disabled
// - reset leaves internal ram contents untouched
// - reset loads default values into peripheral registers
// - vector address is base plus four times vector number 0..31
// - pin and watchdog resets use vector 0, highest priority
// - watchdog nmi uses vector 2 at base plus 0x08
// - vectors 4,7,8,10,11,14,16,18 are maskable; 19..31 reserved
// - equal-level maskable requests: lower vector number wins
// - vector base holds 0x8000 after reset
// - low eight vector base bits fixed at zero
`timescale 1ns/10ps
`include "rvd_consts.vh"
module rvd_reset_dispatch (
	input wire clk_i,
	input wire rst_i,
	input wire reset_pin_n_i,
	input wire [3:0] key_reset_inputs_i,
	input wire wdt_overflow_i,
	input wire [31:0] irq_pending_i,
	input wire [95:0] irq_level_i,
	input wire [2:0] cpu_level_i,
	input wire cpu_ie_i,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire wb_err_o,
	output reg init_reset_o,
	output reg cpu_run_o,
	output reg core_clear_o,
	output reg periph_reset_o,
	output reg [23:0] reset_vec_addr_o,
	output reg nmi_o,
	output reg [23:0] nmi_vec_addr_o,
	output reg irq_o,
	output reg [4:0] irq_vec_o,
	output reg [2:0] irq_lvl_o,
	output reg [23:0] irq_vec_addr_o
);
	// returns base plus four times the vector number
	function [23:0] vec_addr;
		input [15:0] base;
		input [4:0] num;
		begin
			vec_addr = {base, 8'h00} + {17'h00000, num, 2'b00};
		end
	endfunction

	reg [3:0] key_s1_r, key_s2_r;
	reg [7:0] ctrl_r;
	reg [15:0] vbase_r;
	reg [1:0] state_r, state_nxt;
	reg [6:0] cnt_r, cnt_nxt;
	reg [2:0] cause_r;
	reg nmi_pend_r;
	reg rst_q1_r, rst_q2_r;
	wire key_hit, wdt_rst, wdt_nmi, src_rst, hard_rst;
	wire bus_req;
	wire [3:0] key_mask;

	assign key_mask = ctrl_r[`RVD_CTRL_KEY_MASK_LSB +: 4];
	// synchroniser: second stage is the only reader of the first
	always @(posedge clk_i) begin
		key_s1_r <= key_reset_inputs_i;
		key_s2_r <= key_s1_r;
	end
	// empty mask never fires, so an enabled key reset needs at least one port chosen
	assign key_hit = ctrl_r[`RVD_CTRL_KEY_EN] && (key_mask != 4'h0) &&
		((key_s2_r & key_mask) == 4'h0);
	assign wdt_rst = wdt_overflow_i && ctrl_r[`RVD_CTRL_WDT_EN] && ctrl_r[`RVD_CTRL_WDT_SEL];
	assign wdt_nmi = wdt_overflow_i && !ctrl_r[`RVD_CTRL_WDT_SEL];
	assign src_rst = !reset_pin_n_i || key_hit || wdt_rst;
	assign hard_rst = rst_i || src_rst;

	// reset assertion is seen combinationally by the sequencer, release goes through two flops
	always @(posedge clk_i) begin
		if (hard_rst) begin
			rst_q1_r <= 1'b1;
			rst_q2_r <= 1'b1;
		end else begin
			rst_q1_r <= 1'b0;
			rst_q2_r <= rst_q1_r;
		end
	end

	// control and base registers reset on the bus reset rst_i, and the pin, key and wdt paths
	// reset them too, since they are peripheral defaults
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_err_o = 1'b0;
	always @(posedge clk_i) begin
		if (hard_rst) begin
			ctrl_r <= `RVD_CTRL_RST;
			vbase_r <= `RVD_VBASE_RST;
		end else if (bus_req && wb_we_i) begin
			if (wb_adr_i == `RVD_ADR_CTRL && wb_sel_i[0])
				ctrl_r <= wb_dat_i[7:0];
			if (wb_adr_i == `RVD_ADR_VBASE) begin
				if (wb_sel_i[1])
					vbase_r[7:0] <= wb_dat_i[15:8];
				if (wb_sel_i[2])
					vbase_r[15:8] <= wb_dat_i[23:16];
			end
		end
	end

	// record which source caused the last reset; kept until the next source reset overwrites it or rst_i clears it
	always @(posedge clk_i) begin
		if (rst_i)
			cause_r <= 3'h0;
		else if (src_rst)
			cause_r <= {wdt_rst, key_hit, !reset_pin_n_i};
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`RVD_ADR_CTRL: wb_dat_o <= {24'h000000, ctrl_r};
				`RVD_ADR_VBASE: wb_dat_o <= {8'h00, vbase_r, 8'h00};
				`RVD_ADR_STAT: wb_dat_o <= {27'h0, cpu_run_o, state_r, cause_r[1:0] | {1'b0, cause_r[2]}};
				`RVD_ADR_VECREQ: wb_dat_o <= {16'h0000, 5'h00, irq_lvl_o, 3'h0, irq_vec_o};
				default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// release sequencer: oscillator wait then internal hold
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
		`RVD_ST_HOLD: begin
			if (!rst_q2_r) begin
				state_nxt = `RVD_ST_OSC;
				cnt_nxt = `RVD_OSC_WAIT_CYC - 7'h01;
			end
		end
		`RVD_ST_OSC: begin
			if (cnt_r == 7'h00) begin
				state_nxt = `RVD_ST_IRH;
				cnt_nxt = `RVD_HOLD_CYC - 7'h01;
			end else
				cnt_nxt = cnt_r - 7'h01;
		end
		`RVD_ST_IRH: begin
			if (cnt_r == 7'h00)
				state_nxt = `RVD_ST_RUN;
			else
				cnt_nxt = cnt_r - 7'h01;
		end
		`RVD_ST_RUN: state_nxt = `RVD_ST_RUN;
		default: state_nxt = `RVD_ST_HOLD;
		endcase
	end

	always @(posedge clk_i) begin
		if (hard_rst || rst_q2_r) begin
			state_r <= `RVD_ST_HOLD;
			cnt_r <= 7'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// cpu status and vector outputs; the core clears r0-sp, psw on core_clear_o
	// ram has no reset hookup here, so its contents stay as they were
	always @(posedge clk_i) begin
		if (hard_rst) begin
			init_reset_o <= 1'b1;
			core_clear_o <= 1'b1;
			periph_reset_o <= 1'b1;
			cpu_run_o <= 1'b0;
			reset_vec_addr_o <= 24'h000000;
		end else begin
			init_reset_o <= rst_q2_r;
			core_clear_o <= (state_r != `RVD_ST_RUN);
			periph_reset_o <= rst_q2_r;
			cpu_run_o <= (state_r == `RVD_ST_RUN);
			reset_vec_addr_o <= vec_addr(vbase_r, `RVD_VEC_RESET);
		end
	end

	// nmi held until reset; reset has higher priority and wipes it
	always @(posedge clk_i) begin
		if (hard_rst) begin
			nmi_pend_r <= 1'b0;
			nmi_o <= 1'b0;
			nmi_vec_addr_o <= 24'h000000;
		end else begin
			if (wdt_nmi)
				nmi_pend_r <= 1'b1;
			nmi_o <= (nmi_pend_r || wdt_nmi) && cpu_run_o;
			nmi_vec_addr_o <= vec_addr(vbase_r, `RVD_VEC_NMI);
		end
	end

	// maskable arbitration: highest level, then lowest vector number
	reg [4:0] best_v;
	reg [2:0] best_l;
	reg best_ok;
	integer i;
	wire [31:0] mask_map = `RVD_MASKABLE_MAP;
	always @* begin
		best_v = 5'h00;
		best_l = 3'h0;
		best_ok = 1'b0;
		for (i = 31; i >= 0; i = i - 1) begin
			if (mask_map[i] && irq_pending_i[i] && irq_level_i[i*3 +: 3] != 3'h0 &&
				(!best_ok || irq_level_i[i*3 +: 3] >= best_l)) begin
				best_v = i[4:0];
				best_l = irq_level_i[i*3 +: 3];
				best_ok = 1'b1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (hard_rst) begin
			irq_o <= 1'b0;
			irq_vec_o <= 5'h00;
			irq_lvl_o <= 3'h0;
			irq_vec_addr_o <= 24'h000000;
		end else begin
			irq_o <= best_ok && cpu_ie_i && (best_l > cpu_level_i) && cpu_run_o && !nmi_o;
			irq_vec_o <= best_v;
			irq_lvl_o <= best_l;
			irq_vec_addr_o <= vec_addr(vbase_r, best_v);
		end
	end
endmodule // rvd_reset_dispatch

// ==== testbench/rvd_reset_dispatch_props.sv ====
// checker for reset sequencing and vector addresses
`timescale 1ns/10ps
module rvd_props (
	input wire clk_i,
	input wire rst_i,
	input wire reset_pin_n_i,
	input wire [2:0] cpu_level_i,
	input wire cpu_ie_i,
	input wire init_reset_o,
	input wire cpu_run_o,
	input wire core_clear_o,
	input wire periph_reset_o,
	input wire [23:0] reset_vec_addr_o,
	input wire nmi_o,
	input wire [23:0] nmi_vec_addr_o,
	input wire irq_o,
	input wire [4:0] irq_vec_o,
	input wire [2:0] irq_lvl_o,
	input wire [23:0] irq_vec_addr_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_pin; !reset_pin_n_i |-> ##[1:3] init_reset_o; endproperty
	a_pin: assert property (p_pin) else $error("pin low gave no reset");
	property p_hold; init_reset_o |-> !cpu_run_o && core_clear_o && periph_reset_o && !nmi_o && !irq_o; endproperty
	a_hold: assert property (p_hold) else $error("state not held in reset");
	property p_seq; $fell(init_reset_o) |-> ##[94:100] cpu_run_o; endproperty
	a_seq: assert property (p_seq) else $error("cpu start late");
	property p_early; $fell(init_reset_o) |-> !cpu_run_o [*8]; endproperty
	a_early: assert property (p_early) else $error("cpu start early");
	property p_base; cpu_run_o |-> reset_vec_addr_o[7:0] == 8'h00; endproperty
	a_base: assert property (p_base) else $error("base low bits set");
	property p_nmi; nmi_o |-> nmi_vec_addr_o == reset_vec_addr_o + 24'h000008; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi vector address");
	property p_irqa; irq_o |-> irq_vec_addr_o == reset_vec_addr_o + {17'h0, irq_vec_o, 2'b00}; endproperty
	a_irqa: assert property (p_irqa) else $error("irq vector address");
	property p_irqm; irq_o |-> $past(cpu_ie_i) && irq_lvl_o > $past(cpu_level_i); endproperty
	a_irqm: assert property (p_irqm) else $error("irq not masked");
endmodule // rvd_props
bind rvd_reset_dispatch rvd_props u_props (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
	.cpu_level_i(cpu_level_i), .cpu_ie_i(cpu_ie_i), .init_reset_o(init_reset_o), .cpu_run_o(cpu_run_o),
	.core_clear_o(core_clear_o), .periph_reset_o(periph_reset_o), .reset_vec_addr_o(reset_vec_addr_o),
	.nmi_o(nmi_o), .nmi_vec_addr_o(nmi_vec_addr_o), .irq_o(irq_o), .irq_vec_o(irq_vec_o),
	.irq_lvl_o(irq_lvl_o), .irq_vec_addr_o(irq_vec_addr_o));

// ==== testbench/rvd_cpu_model.sv ====
// cpu core model: takes the reset vector when released to run
`timescale 1ns/10ps
module rvd_cpu_model (
	input wire clk_i,
	input wire run_i,
	input wire clear_i,
	input wire [23:0] vec_i,
	output logic [23:0] pc_o
);
	logic run_q;
	always @(posedge clk_i) begin
		run_q <= run_i;
		if (clear_i)
			pc_o <= 24'h000000;
		else if (run_i && !run_q)
			pc_o <= vec_i;
	end
endmodule // rvd_cpu_model

// ==== testbench/tb_rvd_reset_dispatch.sv ====
// testbench for reset and vector dispatch
`timescale 1ns/10ps
module tb_rvd_reset_dispatch;
	logic clk_i = 0, rst_i = 1, pin = 1, wdt = 0, ie = 1, we = 0, cyc = 0, stb = 0;
	logic [3:0] key = 4'hf, adr = 4'h0;
	logic [31:0] pend = 32'h0000_0090, dw = 32'h0, rdat;
	logic [95:0] lvl = 96'h0;
	logic [2:0] cl = 3'h0, ilvl;
	logic [31:0] dr;
	logic ack, err, init, run, clr, prst, nmi, irq;
	logic [23:0] rva, nva, iva, pc;
	logic [4:0] ivec;
	logic [17:0] rows [4] = '{{3'h3, 3'h3, 3'h3, 3'h0, 1'b1, 5'h04}, {3'h5, 3'h2, 3'h5, 3'h0, 1'b1, 5'h07},
		{3'h5, 3'h2, 3'h5, 3'h5, 1'b0, 5'h07}, {3'h0, 3'h0, 3'h0, 3'h0, 1'b0, 5'h00}};
	int miscompares = 0, num_checks = 0, n;
	rvd_reset_dispatch dut (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin), .key_reset_inputs_i(key),
		.wdt_overflow_i(wdt), .irq_pending_i(pend), .irq_level_i(lvl), .cpu_level_i(cl), .cpu_ie_i(ie),
		.wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err), .init_reset_o(init), .cpu_run_o(run),
		.core_clear_o(clr), .periph_reset_o(prst), .reset_vec_addr_o(rva), .nmi_o(nmi),
		.nmi_vec_addr_o(nva), .irq_o(irq), .irq_vec_o(ivec), .irq_lvl_o(ilvl), .irq_vec_addr_o(iva));
	rvd_cpu_model cpu (.clk_i(clk_i), .run_i(run), .clear_i(clr), .vec_i(rva), .pc_o(pc));
	initial forever #4 clk_i = ~clk_i;
	task chk(input [31:0] s, input [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	// request held until the edge that sees ack high; data taken and request dropped there
	task wb(input [3:0] a, input w, input [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = dr;
		{cyc, stb} <= 2'b00;
	endtask
	task wrun;
		n = 0;
		@(negedge clk_i);
		while (run !== 1'b1) begin
			n++;
			@(negedge clk_i);
		end
	endtask
	task pulse(input [7:0] c);
		wb(4'h0, 1, {24'h0, c});
		@(posedge clk_i) wdt <= 1;
		@(posedge clk_i) wdt <= 0;
		@(negedge clk_i);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		wrun;
		@(negedge clk_i);
		chk(pc, 24'h008000);
		wb(4'h4, 0, 0);
		chk(rdat, 32'h0000_8000);
		foreach (rows[i]) begin
			@(posedge clk_i) {lvl[14:12], lvl[23:21], cl} <= rows[i][14:6];
			repeat (3) @(posedge clk_i);
			chk({irq, ivec}, rows[i][5:0]);
			chk(ilvl, rows[i][17:15]);
			if (rows[i][5]) chk(iva, 24'h008000 + 4 * rows[i][4:0]);
		end
		wb(4'h4, 1, 32'h1234_5678);
		wb(4'h4, 0, 0);
		chk(rdat, 32'h0034_5600);
		pulse(8'h00);
		chk({nmi, init}, 2'b10);
		chk(nva, 24'h345608);
		pulse(8'h04);
		chk(init, 0);
		pulse(8'h06);
		chk({nmi, init}, 2'b01);
		wrun;
		wb(4'h4, 0, 0);
		chk(rdat, 32'h0000_8000);
		@(posedge clk_i) key <= 4'h0;
		repeat (4) @(posedge clk_i);
		chk(init, 0);
		key <= 4'hf;
		wb(4'h0, 1, 32'h31);
		@(posedge clk_i) key <= 4'hc;
		repeat (4) @(posedge clk_i);
		chk(init, 1);
		key <= 4'hf;
		wrun;
		@(posedge clk_i) pin <= 0;
		repeat (4) @(posedge clk_i);
		chk({init, run, clr, prst}, 4'b1011);
		pin <= 1;
		wrun;
		chk(n > 95 && n < 101, 1);
		test_done;
	end
endmodule // tb_rvd_reset_dispatch
